// ==== core/psic_cfg.svh ====
// constants for the pipelined sram input control block
`ifndef PSIC_CFG_SVH
`define PSIC_CFG_SVH
`define PSIC_ADDR_W      20
`define PSIC_LANES       4
`define PSIC_LANE_W      9
`define PSIC_BURST_LEN   4
`define PSIC_BURST_W     2
`define PSIC_BURST_ONE   2'h1
`define PSIC_BURST_ZERO  2'h0
`endif

// ==== core/psic_input_ctrl.sv ====
// input capture, burst counter and output-enable control of a pipelined sram
`timescale 1ns/1ps
`default_nettype none
`include "psic_cfg.svh"
module psic_input_ctrl
	import psic_pkg::*;
#(
	parameter int ADDR_W = `PSIC_ADDR_W,
	parameter int LANES  = `PSIC_LANES
) (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 clock_qualifier_n,
	input  wire psic_ctrl_type        ctrl,
	input  wire logic [ADDR_W-1:0]    addr,
	input  wire logic                 burst_interleaved,
	output logic [ADDR_W-1:0]         access_addr_q,
	output logic [LANES-1:0]          lane_write_en_q,
	output logic                      write_cycle_q,
	output logic                      read_cycle_q,
	output logic                      data_out_mask_q
);
	logic                     qual;          // effective edge
	logic                     sel_now;       // chip selects decode
	logic                     selected_q;    // device selected at the last qualified load cycle
	logic                     mode_q;        // strap caught during reset
	logic [ADDR_W-1:0]        base_q;        // loaded address
	logic [`PSIC_BURST_W-1:0] cnt_q;         // burst step count
	logic [`PSIC_BURST_W-1:0] cnt_d;         // next burst step
	logic [`PSIC_BURST_W-1:0] low_bits;      // burst address low bits
	psic_op_type              op_q;          // access of the current cycle
	psic_op_type              load_op;       // kind a load cycle would start

	// qualifier and select decode are plain gates on the sampled pins; next count adds one to cnt_q
	assign qual    = ~clock_qualifier_n;
	assign sel_now = ~ctrl.chip_select_one_n & ctrl.chip_select_two & ~ctrl.chip_select_three_n;
	assign cnt_d   = cnt_q + `PSIC_BURST_ONE; // wraps after four steps

	// burst order: xor for interleaved, add for linear
	// built from the next count, so the address lands with the step itself
	always_comb begin
		if (mode_q) begin
			low_bits = base_q[`PSIC_BURST_W-1:0] ^ cnt_d;
		end else begin
			low_bits = base_q[`PSIC_BURST_W-1:0] + cnt_d;
		end
	end

	// access kind a load cycle would start; advance cycles never use it
	always_comb begin
		if (!sel_now) begin
			load_op = PSIC_IDLE;
		end else if (!ctrl.write_strobe_n) begin
			load_op = PSIC_WRITE;
		end else begin
			load_op = PSIC_READ;
		end
	end

	// strap is static, so sample it once per clock while in reset
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_q <= burst_interleaved;
		end
	end

	// address load or burst advance
	always_ff @(posedge clk) begin
		if (reset) begin
			base_q <= '0;
			cnt_q  <= `PSIC_BURST_ZERO;
		end else if (qual) begin
			if (!ctrl.advance_or_load) begin
				base_q <= addr;
				cnt_q  <= `PSIC_BURST_ZERO;
			end else begin
				cnt_q <= cnt_d;
			end
		end
	end

	// access address presented to the array
	always_ff @(posedge clk) begin
		if (reset) begin
			access_addr_q <= '0;
		end else if (qual) begin
			if (!ctrl.advance_or_load) begin
				access_addr_q <= addr;
			end else begin
				// high bits stay in the loaded block, only the low pair walks
				access_addr_q <= {base_q[ADDR_W-1:`PSIC_BURST_W], low_bits};
			end
		end
	end

	// access kind and selection; advance keeps previous selection
	// a burst that starts selected stays selected until the next load
	always_ff @(posedge clk) begin
		if (reset) begin
			op_q       <= PSIC_IDLE;
			selected_q <= 1'b0;
		end else if (qual) begin
			if (ctrl.advance_or_load) begin
				op_q <= op_q; // burst continues same kind
			end else if (!sel_now) begin
				op_q <= PSIC_IDLE;
			end else if (!ctrl.write_strobe_n) begin
				op_q <= PSIC_WRITE;
			end else begin
				op_q <= PSIC_READ;
			end
			selected_q <= ctrl.advance_or_load ? selected_q : sel_now;
		end
	end

	// lane enables cover data byte and parity bit together; a burst step keeps the
	// kind and lanes of its load, since the strobe is not asserted on advance cycles
	// and lane selects alone must never open a lane
	always_ff @(posedge clk) begin
		if (reset) begin
			lane_write_en_q <= '0;
			write_cycle_q   <= 1'b0;
			read_cycle_q    <= 1'b0;
		end else if (qual && !ctrl.advance_or_load) begin
			case (load_op)
				PSIC_WRITE: begin
					write_cycle_q   <= 1'b1;
					read_cycle_q    <= 1'b0;
					lane_write_en_q <= ~ctrl.lane_write_sel_n;
				end
				PSIC_READ: begin
					write_cycle_q   <= 1'b0;
					read_cycle_q    <= 1'b1;
					lane_write_en_q <= '0;
				end
				default: begin // deselected load starts no access
					write_cycle_q   <= 1'b0;
					read_cycle_q    <= 1'b0;
					lane_write_en_q <= '0;
				end
			endcase
		end
	end

	// output mask: write data phase, first cycle out of deselect, deselected
	always_ff @(posedge clk) begin
		if (reset) begin
			data_out_mask_q <= 1'b1;
		end else if (qual) begin
			data_out_mask_q <= ~(ctrl.advance_or_load ? selected_q : sel_now)
				| ~selected_q
				| ~(ctrl.advance_or_load ? (op_q != PSIC_WRITE) : ctrl.write_strobe_n);
		end
	end

	// a cycle without qualifier leaves access address and lane enables unchanged
	a_hold_when_stalled: assert property (@(posedge clk) disable iff (reset)
		!$past(qual) && !$past(reset) |-> $stable(access_addr_q) && $stable(lane_write_en_q))
		else $error("outputs moved on a masked edge");
	// load takes the address
	a_load_takes_addr: assert property (@(posedge clk) disable iff (reset)
		qual && !ctrl.advance_or_load |=> access_addr_q == $past(addr))
		else $error("load did not capture address");
	// no lanes on a load without write strobe
	a_lane_needs_write: assert property (@(posedge clk) disable iff (reset)
		qual && !ctrl.advance_or_load && ctrl.write_strobe_n |=> lane_write_en_q == '0)
		else $error("lane written without strobe");
	// deselect masks data outputs
	a_deselect_masks: assert property (@(posedge clk) disable iff (reset)
		qual && !ctrl.advance_or_load && !sel_now |=> data_out_mask_q)
		else $error("outputs driven while deselected");
	// counter steps on advance
	a_counter_steps: assert property (@(posedge clk) disable iff (reset)
		qual && ctrl.advance_or_load |=> cnt_q == $past(cnt_q) + `PSIC_BURST_ONE)
		else $error("burst counter did not step");
	// selection decode
	a_select_decode: assert property (@(posedge clk) disable iff (reset)
		qual && !ctrl.advance_or_load && ctrl.chip_select_two && !ctrl.chip_select_one_n
		&& !ctrl.chip_select_three_n && ctrl.write_strobe_n |=> read_cycle_q)
		else $error("selected read not started");
	// write strobe honoured
	a_write_starts: assert property (@(posedge clk) disable iff (reset)
		qual && !ctrl.advance_or_load && sel_now && !ctrl.write_strobe_n |=> write_cycle_q)
		else $error("write not started");
	// address high bits kept during burst
	a_burst_block: assert property (@(posedge clk) disable iff (reset)
		qual && ctrl.advance_or_load |=> access_addr_q[ADDR_W-1:`PSIC_BURST_W] == $past(base_q[ADDR_W-1:`PSIC_BURST_W]))
		else $error("burst left its block");

	// a qualified load with the device selected
	sequence s_load_sel;
		qual && !ctrl.advance_or_load && sel_now;
	endsequence
	// a qualified burst step
	sequence s_advance;
		qual && ctrl.advance_or_load;
	endsequence
	// a qualified load with the device deselected
	sequence s_deselect;
		qual && !ctrl.advance_or_load && !sel_now;
	endsequence
	// a burst step keeps the lanes and kind chosen by its load
	a_burst_keeps_lanes: assert property (@(posedge clk) disable iff (reset)
		s_load_sel ##1 s_advance |=> $stable(lane_write_en_q) && $stable(write_cycle_q))
		else $error("burst step changed lanes");
	// first load out of deselect keeps data outputs masked
	a_wake_masks: assert property (@(posedge clk) disable iff (reset)
		s_deselect ##1 s_load_sel |=> data_out_mask_q)
		else $error("outputs driven leaving deselect");
endmodule : psic_input_ctrl
`default_nettype wire

// ==== core/psic_pkg.sv ====
// types for the pipelined sram input control block
`include "psic_cfg.svh"
package psic_pkg;
	// access kind of the captured cycle
	typedef enum logic [1:0] {
		PSIC_IDLE  = 2'b00,
		PSIC_READ  = 2'b01,
		PSIC_WRITE = 2'b10
	} psic_op_type;
	// control group sampled from the controller
	typedef struct packed {
		logic                    chip_select_one_n;
		logic                    chip_select_two;
		logic                    chip_select_three_n;
		logic                    write_strobe_n;
		logic                    advance_or_load;
		logic [`PSIC_LANES-1:0]  lane_write_sel_n;
	} psic_ctrl_type;
endpackage : psic_pkg

// ==== tb/pipelined_sram_input_control_bench.sv ====
// self-checking bench for the sram input control block
`timescale 1ns/1ps
`default_nettype none
`include "psic_cfg.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; $display("ERROR %s exp %h got %h", n, e, s); end end
module pipelined_sram_input_control_bench
	import psic_pkg::*;
;
	logic                    clk = 1'b0, reset = 1'b1, strap = 1'b1;
	logic [2:0]              op = 3'h4;
	logic [31:0]             rnd = 32'h000149a5;
	psic_ctrl_type           ctrl;
	logic [`PSIC_ADDR_W-1:0] addr, acc, e_a;
	logic [3:0]              lanes, e_l;
	logic                    qn, wr, rd, mask, e_w, e_r, e_m, sel_q;
	logic [1:0]              cnt, b2;
	int                      mismatches = 0, compares = 0;
	logic [2:0]              corner [14] = '{3'h0, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h2,
	                                         3'h3, 3'h1, 3'h2, 3'h1, 3'h3, 3'h3, 3'h1};
	always #2.5 clk = ~clk;
	psic_ctrl_model i_model (.op(op), .rnd(rnd), .ctrl(ctrl), .addr(addr), .clock_qualifier_n(qn));
	psic_input_ctrl i_dut (.clk(clk), .reset(reset), .clock_qualifier_n(qn), .ctrl(ctrl), .addr(addr),
		.burst_interleaved(strap), .access_addr_q(acc), .lane_write_en_q(lanes), .write_cycle_q(wr),
		.read_cycle_q(rd), .data_out_mask_q(mask));
	// galois shift register keeps the random stream repeatable
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr
	task automatic end_of_test();
		if (mismatches == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// reset with the strap held steady, then expect the quiet state
	task automatic do_reset(input logic s);
		@(negedge clk);
		op = 3'h4;
		reset = 1'b1;
		strap = s;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		{e_a, e_l, e_w, e_r, e_m, sel_q} = {{`PSIC_ADDR_W{1'b0}}, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0};
	endtask : do_reset
	// compare what the last qualified edge left behind, then drive the next cycle
	task automatic step(input logic [2:0] o);
		@(negedge clk);
		`CHK("write", e_w, wr)
		`CHK("read", e_r, rd)
		`CHK("lanes", e_l, lanes)
		`CHK("mask", e_m, mask)
		if (e_w | e_r) `CHK("addr", e_a, acc)
		rnd = lfsr(rnd);
		if (o == 3'h7) o = 3'(rnd[22:20] % 3'h5);
		if (o == 3'h2 && !sel_q) o = {2'h0, rnd[0]};
		op = o;
		#1;
		case (op)
			3'h0, 3'h1: begin // fresh address from the pins
				e_a = addr;
				b2 = addr[1:0];
				cnt = 2'h0;
				e_w = (op == 3'h0);
				e_r = (op == 3'h1);
				e_l = e_w ? ~ctrl.lane_write_sel_n : 4'h0;
				e_m = e_w | !sel_q;
				sel_q = 1'b1;
			end
			3'h2: begin // next burst slot wraps in four
				cnt = cnt + 2'h1;
				e_a[1:0] = strap ? (b2 ^ cnt) : (b2 + cnt);
				e_m = e_w;
			end
			3'h3: begin
				{e_w, e_r, e_l, e_m, sel_q} = {1'b0, 1'b0, 4'h0, 1'b1, 1'b0};
			end
			default: ; // held edge changes nothing
		endcase
	endtask : step
	// both burst orders: corner list first, then random traffic
	initial begin
		for (int m = 1; m >= 0; m--) begin
			do_reset(m[0]);
			foreach (corner[i]) step(corner[i]);
			repeat (400) step(3'h7);
		end
		step(3'h4);
		end_of_test();
	end
endmodule : pipelined_sram_input_control_bench
`default_nettype wire

// ==== tb/psic_ctrl_model.sv ====
// controller model that drives the sram input control pins
`timescale 1ns/1ps
`default_nettype none
`include "psic_cfg.svh"
module psic_ctrl_model
	import psic_pkg::*;
(
	input  wire logic [2:0]               op,
	input  wire logic [31:0]              rnd,
	output var psic_ctrl_type             ctrl,
	output logic [`PSIC_ADDR_W-1:0]       addr,
	output logic                          clock_qualifier_n
);
	// op 0 write load, 1 read load, 2 advance, 3 deselect, 4 stall
	// unused lines churn with the random word so that no stale value looks valid
	always_comb begin
		ctrl = psic_ctrl_type'(rnd[31:23]);
		addr = rnd[`PSIC_ADDR_W-1:0];
		clock_qualifier_n = (op == 3'h4);
		if (op < 3'h3) begin
			ctrl.chip_select_one_n   = 1'b0;
			ctrl.chip_select_two     = 1'b1;
			ctrl.chip_select_three_n = 1'b0;
			ctrl.write_strobe_n      = (op != 3'h0);
			ctrl.advance_or_load     = (op == 3'h2);
		end else if (op == 3'h3) begin
			// deselect is a load with the selects off, never a burst step
			ctrl.advance_or_load = 1'b0;
			if (rnd[31:29] == 3'h2) begin
				ctrl.chip_select_two = 1'b0; // random selects must still deselect
			end
		end
	end
endmodule : psic_ctrl_model
`default_nettype wire
